// File: hw/pkt_test_params.svh
`ifndef PKT_TEST_PARAMS_SVH
`define PKT_TEST_PARAMS_SVH
// register offsets on the management port
`define OFS_EQ_CLEAR 8'h01
`define OFS_PLL_RST 8'h02
`define OFS_RX_ALIGN 8'h03
`define OFS_WORD_LOCK 8'h04
`define OFS_SYNC_LOCK 8'h05
`define OFS_CRC32_LO 8'h06
`define OFS_CRC32_HI 8'h09
`define OFS_CRC24 8'h0A
`define OFS_FIFO_FLAGS 8'h0B
`define OFS_RX_SOP_CNT 8'h0C
`define OFS_RX_EOP_CNT 8'h0D
`define OFS_ERR_CNT 8'h0E
`define OFS_GEN_EN 8'h0F
`define OFS_CHK_ERR 8'h10
`define OFS_PLL_LOCK 8'h11
`define OFS_LATENCY 8'h13
`define OFS_TX_SOP_CNT 8'h14
`define OFS_TX_EOP_CNT 8'h15
`define OFS_CONT 8'h16
`define OFS_CNT_EQUAL 8'h17
`define OFS_LAT_START 8'h23
`define OFS_LAT_READY 8'h24
`define OFS_ECC_DET 8'h39
`define OFS_ECC_CORR 8'h40
// field positions
`define BIT_PLL_RST_REQ 0
`define BIT_PLL_RST_EN 1
`define BIT_RX_OVF 1
`define BIT_TX_OVF 2
`define BIT_TX_UNF 3
`define BIT_CHK_SOP 0
`define BIT_CHK_CHAN 1
`define BIT_CHK_PLD 2
`define BIT_CHK_SEQ 3
// reset values
`define RST_WORD 32'h0000_0000
`endif

// File: hw/pkt_test_pkg.sv
package pkt_test_pkg;
    typedef logic [7:0] addr_t;
    typedef logic [31:0] word_t;
    typedef logic [63:0] beat_t;
    typedef logic [7:0] chan_t;
    typedef enum logic [1:0] {
        GEN_IDLE = 2'b00,
        GEN_SOP = 2'b01,
        GEN_BODY = 2'b10
    } gen_state_e;
    typedef enum logic [1:0] {
        LAT_IDLE = 2'b00,
        LAT_ARM = 2'b01,
        LAT_RUN = 2'b10
    } lat_state_e;
endpackage

// File: hw/pkt_gen.sv
`timescale 1ns/1ps
`default_nettype none
module pkt_gen #(
    parameter int PKT_WORDS = 8,
    parameter int RUN_PKTS = 100
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic continuous,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic tx_sop,
    output logic tx_eop,
    output pkt_test_pkg::beat_t tx_data,
    output pkt_test_pkg::chan_t tx_chan
);
    import pkt_test_pkg::*;
    gen_state_e state;
    logic [31:0] seq;
    logic [7:0] idx;
    logic [31:0] sent;
    wire run_done = !continuous && (sent >= 32'(RUN_PKTS));
    wire beat = tx_valid && tx_ready;
    // payload: sequence number over word index
    assign tx_valid = (state != GEN_IDLE);
    assign tx_sop = (state == GEN_SOP);
    assign tx_eop = tx_valid && (idx == 8'(PKT_WORDS - 1));
    assign tx_data = {seq, 24'h00_0000, idx};
    assign tx_chan = seq[7:0];
    // stop only at a packet boundary
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= GEN_IDLE;
            seq <= 32'h0000_0000;
            idx <= 8'h00;
            sent <= 32'h0000_0000;
        end else begin
            case (state)
                GEN_IDLE: begin
                    if (!enable) begin
                        sent <= 32'h0000_0000; // re-arm the bounded run
                    end else if (!run_done) begin
                        state <= GEN_SOP;
                    end
                end
                GEN_SOP, GEN_BODY: begin
                    if (beat && tx_eop) begin
                        idx <= 8'h00;
                        seq <= seq + 32'h0000_0001;
                        sent <= sent + 32'h0000_0001;
                        state <= GEN_IDLE;
                    end else if (beat) begin
                        idx <= idx + 8'h01;
                        state <= GEN_BODY;
                    end
                end
                default: state <= GEN_IDLE;
            endcase
        end
    end
endmodule // pkt_gen
`default_nettype wire

// File: hw/pkt_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pkt_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rx_valid,
    input wire logic rx_sop,
    input wire logic rx_eop,
    input wire pkt_test_pkg::beat_t rx_data,
    input wire pkt_test_pkg::chan_t rx_chan,
    output logic sop_err,
    output logic chan_err,
    output logic pld_err,
    output logic seq_err,
    output logic frame_err
);
    import pkt_test_pkg::*;
    logic in_pkt;
    logic [31:0] exp_seq;
    logic [31:0] cur_seq;
    logic [7:0] idx;
    wire first = rx_valid && rx_sop;
    wire body = rx_valid && !rx_sop && in_pkt;
    wire [31:0] got_seq = rx_data[63:32];
    // start inside a packet or data outside one: lost marker
    wire miss = rx_valid && (rx_sop == in_pkt);
    // one-cycle error pulses, a cycle late
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_pkt <= 1'b0;
            exp_seq <= 32'h0000_0000;
            cur_seq <= 32'h0000_0000;
            idx <= 8'h00;
            sop_err <= 1'b0;
            chan_err <= 1'b0;
            pld_err <= 1'b0;
            seq_err <= 1'b0;
            frame_err <= 1'b0;
        end else begin
            sop_err <= first && (rx_data[31:0] != 32'h0000_0000);
            chan_err <= first && (rx_chan != got_seq[7:0]);
            seq_err <= first && (got_seq != exp_seq);
            pld_err <= body && (rx_data != {cur_seq, 24'h00_0000, idx});
            frame_err <= miss;
            if (first) begin
                // resync so one slip flags once
                exp_seq <= got_seq + 32'h0000_0001;
                cur_seq <= got_seq;
                idx <= 8'h01;
                in_pkt <= !rx_eop;
            end else if (body) begin
                idx <= idx + 8'h01;
                in_pkt <= !rx_eop;
            end
        end
    end
endmodule // pkt_chk
`default_nettype wire

// File: hw/packet_test_status_regs.sv
// Behaviour
// - gen enable bit 0 starts/stops generator
// - continuous bit 0 makes generation unbounded
// - counter-reset write clears equal flag
// - look-aside flag when tx/rx counts equal
// - latency-enable write starts latency measurement
// - latency ready flag and latency count
// - pll reset request bit0, enable bit1
// - word lock one bit per lane
// - metaframe sync one bit per lane
// - 128-bit crc32 and 32-bit crc24 error counters
// - fifo underflow/overflow flags bits 3,2,1
// - count received start and end markers
// - error counter for link framing faults
// - checker flags sop, channel, payload mismatch
// - pll lock reported in bit 0
// - count generated start and end markers
// - ecc detected and corrected counts
// - rx lane alignment status readable
// - reset, loopback, stream, check, report
// - checker flags out-of-order packet sequence
`timescale 1ns/1ps
`default_nettype none
`include "pkt_test_params.svh"
module packet_test_status_regs #(
    parameter int NUM_LANES = 8,
    parameter int PKT_WORDS = 8,
    parameter int RUN_PKTS = 100,
    parameter bit LOOKASIDE = 1'b0
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire pkt_test_pkg::addr_t MM_ADDR,
    input wire logic MM_WRITE,
    input wire logic MM_READ,
    input wire pkt_test_pkg::word_t MM_WDATA,
    output pkt_test_pkg::word_t MM_RDATA,
    output logic MM_RDVALID,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic TX_SOP,
    output logic TX_EOP,
    output pkt_test_pkg::beat_t TX_DATA,
    output pkt_test_pkg::chan_t TX_CHANNEL,
    input wire logic RX_VALID,
    input wire logic RX_SOP,
    input wire logic RX_EOP,
    input wire pkt_test_pkg::beat_t RX_DATA,
    input wire pkt_test_pkg::chan_t RX_CHANNEL,
    input wire logic RX_ALIGNED,
    input wire logic [NUM_LANES-1:0] WORD_LOCK,
    input wire logic [NUM_LANES-1:0] SYNC_LOCK,
    input wire logic CRC32_ERR,
    input wire logic CRC24_ERR,
    input wire logic TX_UNDERFLOW,
    input wire logic TX_OVERFLOW,
    input wire logic RX_OVERFLOW,
    input wire logic LANE_ALIGN_LOSS,
    input wire logic ILLEGAL_CTRL_WORD,
    input wire logic ILLEGAL_FRAMING,
    input wire logic ECC_DETECTED,
    input wire logic ECC_CORRECTED,
    input wire logic PLL_LOCKED,
    input wire logic PLL_RST_REQ,
    input wire logic PLL_RST_EN
);
    import pkt_test_pkg::*;

    // refuse lane counts that do not fit one register word
    if (NUM_LANES < 1 || NUM_LANES > 32) begin : g_bad_lanes
        $error("NUM_LANES out of range");
    end
    if (PKT_WORDS < 1 || PKT_WORDS > 256) begin : g_bad_len
        $error("PKT_WORDS out of range");
    end
    if (RUN_PKTS < 1) begin : g_bad_run
        $error("RUN_PKTS must be at least 1");
    end

    // control registers
    logic gen_enable;
    logic cont_enable;
    logic equal_flag;
    logic equal_q;
    lat_state_e lat_state;
    logic lat_ready;
    word_t lat_timer;
    word_t lat_result;

    // counters and sticky flags
    logic [127:0] crc32_cnt;
    word_t crc24_cnt;
    word_t rx_sop_cnt;
    word_t rx_eop_cnt;
    word_t tx_sop_cnt;
    word_t tx_eop_cnt;
    word_t err_cnt;
    word_t ecc_det_cnt;
    word_t ecc_corr_cnt;
    logic [3:0] fifo_flags;
    logic [3:0] chk_flags;

    // checker pulses
    logic chk_sop_err;
    logic chk_chan_err;
    logic chk_pld_err;
    logic chk_seq_err;
    logic chk_frame_err;

    // generator drives the transmit interface
    pkt_gen #(
        .PKT_WORDS(PKT_WORDS),
        .RUN_PKTS(RUN_PKTS)
    ) u_gen (
        .clk(CLK),
        .rst_n(RST_N),
        .enable(gen_enable),
        .continuous(cont_enable),
        .tx_ready(TX_READY),
        .tx_valid(TX_VALID),
        .tx_sop(TX_SOP),
        .tx_eop(TX_EOP),
        .tx_data(TX_DATA),
        .tx_chan(TX_CHANNEL)
    );

    // checker watches the looped-back receive stream
    pkt_chk u_chk (
        .clk(CLK),
        .rst_n(RST_N),
        .rx_valid(RX_VALID),
        .rx_sop(RX_SOP),
        .rx_eop(RX_EOP),
        .rx_data(RX_DATA),
        .rx_chan(RX_CHANNEL),
        .sop_err(chk_sop_err),
        .chan_err(chk_chan_err),
        .pld_err(chk_pld_err),
        .seq_err(chk_seq_err),
        .frame_err(chk_frame_err)
    );

    // address decode for writes
    wire wr_gen = MM_WRITE && (MM_ADDR == `OFS_GEN_EN);
    wire wr_cont = MM_WRITE && (MM_ADDR == `OFS_CONT);
    wire wr_eq_clr = MM_WRITE && LOOKASIDE && (MM_ADDR == `OFS_EQ_CLEAR);
    wire wr_eq = MM_WRITE && LOOKASIDE && (MM_ADDR == `OFS_CNT_EQUAL);
    wire wr_lat = MM_WRITE && LOOKASIDE && (MM_ADDR == `OFS_LAT_START);

    // marker events on both user interfaces
    wire tx_sop_fire = TX_VALID && TX_READY && TX_SOP;
    wire tx_eop_fire = TX_VALID && TX_READY && TX_EOP;
    wire rx_sop_fire = RX_VALID && RX_SOP;
    wire rx_eop_fire = RX_VALID && RX_EOP;

    // equality of both marker counts
    wire equal_now = (tx_sop_cnt == rx_sop_cnt) && (tx_eop_cnt == rx_eop_cnt);
    // set on rising equality so a clear sticks
    wire equal_set = LOOKASIDE && equal_now && !equal_q;
    wire equal_clr = (wr_eq_clr && MM_WDATA[0]) || (wr_eq && !MM_WDATA[0]);

    // framing faults or a lost marker bump the count
    wire link_err = LANE_ALIGN_LOSS || ILLEGAL_CTRL_WORD || ILLEGAL_FRAMING
        || chk_frame_err;

    // enable bits written by software
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            gen_enable <= 1'b0;
            cont_enable <= 1'b0;
        end else begin
            if (wr_gen) begin
                gen_enable <= MM_WDATA[0];
            end
            if (wr_cont) begin
                cont_enable <= MM_WDATA[0];
            end
        end
    end

    // equality flag: set wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            equal_flag <= 1'b0;
            equal_q <= 1'b1;
        end else begin
            equal_q <= equal_now;
            if (equal_set) begin
                equal_flag <= 1'b1;
            end else if (equal_clr) begin
                equal_flag <= 1'b0;
            end
        end
    end

    // latency: next generated start to next received start;
    // a start in flight when armed shortens the figure,
    // so arm while the link is idle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lat_state <= LAT_IDLE;
            lat_ready <= 1'b0;
            lat_timer <= `RST_WORD;
            lat_result <= `RST_WORD;
        end else begin
            case (lat_state)
                LAT_IDLE: begin
                    if (wr_lat && MM_WDATA[0]) begin
                        lat_state <= LAT_ARM;
                        lat_ready <= 1'b0;
                    end
                end
                LAT_ARM: begin
                    if (tx_sop_fire) begin
                        lat_timer <= `RST_WORD;
                        lat_state <= LAT_RUN;
                    end
                end
                LAT_RUN: begin
                    lat_timer <= lat_timer + 32'h0000_0001;
                    if (rx_sop_fire) begin
                        lat_result <= lat_timer + 32'h0000_0001;
                        lat_ready <= 1'b1;
                        lat_state <= LAT_IDLE;
                    end
                end
                default: lat_state <= LAT_IDLE;
            endcase
        end
    end

    // error counters from the link core
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            crc32_cnt <= 128'h0;
            crc24_cnt <= `RST_WORD;
            err_cnt <= `RST_WORD;
        end else begin
            crc32_cnt <= crc32_cnt + {127'h0, CRC32_ERR};
            crc24_cnt <= crc24_cnt + {31'h0, CRC24_ERR};
            err_cnt <= err_cnt + {31'h0, link_err};
        end
    end

    // marker counters; counts wrap rather than saturate
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rx_sop_cnt <= `RST_WORD;
            rx_eop_cnt <= `RST_WORD;
            tx_sop_cnt <= `RST_WORD;
            tx_eop_cnt <= `RST_WORD;
        end else begin
            rx_sop_cnt <= rx_sop_cnt + {31'h0, rx_sop_fire};
            rx_eop_cnt <= rx_eop_cnt + {31'h0, rx_eop_fire};
            tx_sop_cnt <= tx_sop_cnt + {31'h0, tx_sop_fire};
            tx_eop_cnt <= tx_eop_cnt + {31'h0, tx_eop_fire};
        end
    end

    // ecc counters
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ecc_det_cnt <= `RST_WORD;
            ecc_corr_cnt <= `RST_WORD;
        end else begin
            ecc_det_cnt <= ecc_det_cnt + {31'h0, ECC_DETECTED};
            ecc_corr_cnt <= ecc_corr_cnt + {31'h0, ECC_CORRECTED};
        end
    end

    // sticky fifo and checker flags, held until reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fifo_flags <= 4'h0;
            chk_flags <= 4'h0;
        end else begin
            fifo_flags[`BIT_RX_OVF] <= fifo_flags[`BIT_RX_OVF] | RX_OVERFLOW;
            fifo_flags[`BIT_TX_OVF] <= fifo_flags[`BIT_TX_OVF] | TX_OVERFLOW;
            fifo_flags[`BIT_TX_UNF] <= fifo_flags[`BIT_TX_UNF] | TX_UNDERFLOW;
            chk_flags[`BIT_CHK_SOP] <= chk_flags[`BIT_CHK_SOP] | chk_sop_err;
            chk_flags[`BIT_CHK_CHAN] <= chk_flags[`BIT_CHK_CHAN] | chk_chan_err;
            chk_flags[`BIT_CHK_PLD] <= chk_flags[`BIT_CHK_PLD] | chk_pld_err;
            chk_flags[`BIT_CHK_SEQ] <= chk_flags[`BIT_CHK_SEQ] | chk_seq_err;
        end
    end

    // read decode; crc32 count is spread over four words, low word first
    wire [7:0] crc_word = MM_ADDR - `OFS_CRC32_LO;
    wire crc_hit = (MM_ADDR >= `OFS_CRC32_LO) && (MM_ADDR <= `OFS_CRC32_HI);
    wire [31:0] crc_slice = crc32_cnt[crc_word[1:0]*32 +: 32];
    wire [31:0] word_lock_rd = 32'(WORD_LOCK);
    wire [31:0] sync_lock_rd = 32'(SYNC_LOCK);
    word_t rd_word;
    // other-mode registers read as zero
    always_comb begin
        if (MM_ADDR == `OFS_PLL_RST) begin
            rd_word = {30'h0, PLL_RST_EN, PLL_RST_REQ};
        end else if (MM_ADDR == `OFS_RX_ALIGN) begin
            rd_word = {31'h0, RX_ALIGNED};
        end else if (MM_ADDR == `OFS_WORD_LOCK) begin
            rd_word = word_lock_rd;
        end else if (MM_ADDR == `OFS_SYNC_LOCK) begin
            rd_word = sync_lock_rd;
        end else if (crc_hit) begin
            rd_word = crc_slice;
        end else if (MM_ADDR == `OFS_CRC24) begin
            rd_word = crc24_cnt;
        end else if (MM_ADDR == `OFS_FIFO_FLAGS && !LOOKASIDE) begin
            rd_word = {28'h0, fifo_flags};
        end else if (MM_ADDR == `OFS_RX_SOP_CNT) begin
            rd_word = rx_sop_cnt;
        end else if (MM_ADDR == `OFS_RX_EOP_CNT) begin
            rd_word = rx_eop_cnt;
        end else if (MM_ADDR == `OFS_ERR_CNT) begin
            rd_word = err_cnt;
        end else if (MM_ADDR == `OFS_GEN_EN) begin
            rd_word = {31'h0, gen_enable};
        end else if (MM_ADDR == `OFS_CHK_ERR) begin
            rd_word = {28'h0, chk_flags};
        end else if (MM_ADDR == `OFS_PLL_LOCK) begin
            rd_word = {31'h0, PLL_LOCKED};
        end else if (MM_ADDR == `OFS_LATENCY && LOOKASIDE) begin
            rd_word = lat_result;
        end else if (MM_ADDR == `OFS_TX_SOP_CNT) begin
            rd_word = tx_sop_cnt;
        end else if (MM_ADDR == `OFS_TX_EOP_CNT) begin
            rd_word = tx_eop_cnt;
        end else if (MM_ADDR == `OFS_CONT) begin
            rd_word = {31'h0, cont_enable};
        end else if (MM_ADDR == `OFS_CNT_EQUAL && LOOKASIDE) begin
            rd_word = {31'h0, equal_flag};
        end else if (MM_ADDR == `OFS_LAT_READY && LOOKASIDE) begin
            rd_word = {31'h0, lat_ready};
        end else if (MM_ADDR == `OFS_ECC_DET && !LOOKASIDE) begin
            rd_word = ecc_det_cnt;
        end else if (MM_ADDR == `OFS_ECC_CORR && !LOOKASIDE) begin
            rd_word = ecc_corr_cnt;
        end else begin
            rd_word = `RST_WORD; // unmapped and write-only offsets
        end
    end

    // registered answer, a cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            MM_RDATA <= `RST_WORD;
            MM_RDVALID <= 1'b0;
        end else begin
            MM_RDVALID <= MM_READ;
            if (MM_READ) begin
                MM_RDATA <= rd_word;
            end
        end
    end
endmodule // packet_test_status_regs
`default_nettype wire

// File: dv/packet_test_status_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pts_monitor (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic MM_READ,
    input wire pkt_test_pkg::word_t MM_RDATA,
    input wire logic MM_RDVALID,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic TX_SOP,
    input wire logic TX_EOP,
    input wire pkt_test_pkg::beat_t TX_DATA,
    input wire pkt_test_pkg::chan_t TX_CHANNEL
);
    import pkt_test_pkg::*;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // one answer per read strobe
    a_read_answer: assert property (MM_READ |=> MM_RDVALID)
        else $error("read unanswered");
    a_no_stray: assert property (!MM_READ |=> !MM_RDVALID)
        else $error("stray answer");
    a_data_holds: assert property (!MM_READ |=> $stable(MM_RDATA))
        else $error("read data moved");
    // stalled beat holds
    a_beat_stalls: assert property (
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_SOP))
        else $error("beat changed while stalled");
    a_gap_after_end: assert property (
        TX_VALID && TX_READY && TX_EOP |=> !TX_VALID)
        else $error("no gap after end");
    a_start_first: assert property (
        $rose(TX_VALID) |-> TX_SOP && TX_DATA[7:0] == 8'h00)
        else $error("bad packet start");
    a_chan_seq: assert property (TX_VALID |-> TX_CHANNEL == TX_DATA[39:32])
        else $error("channel not sequence");
    a_second_word: assert property (
        TX_VALID && TX_READY && TX_SOP |=> TX_VALID && TX_DATA[7:0] == 8'h01
        && TX_DATA[63:32] == $past(TX_DATA[63:32]))
        else $error("bad second word");
    // reset quiets both ports
    a_reset_clears: assert property (disable iff (1'b0) !RST_N |=>
        !TX_VALID && !MM_RDVALID && MM_RDATA == 32'h0000_0000)
        else $error("reset did not clear");
endmodule // pts_monitor
bind packet_test_status_regs pts_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .MM_READ(MM_READ),
    .MM_RDATA(MM_RDATA), .MM_RDVALID(MM_RDVALID), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TX_SOP(TX_SOP), .TX_EOP(TX_EOP), .TX_DATA(TX_DATA), .TX_CHANNEL(TX_CHANNEL));
`default_nettype wire

// File: dv/loop_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module loop_link_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic bad_chan,
    input wire logic tx_valid,
    input wire logic tx_sop,
    input wire logic tx_eop,
    input wire pkt_test_pkg::beat_t tx_data,
    input wire pkt_test_pkg::chan_t tx_chan,
    output logic tx_ready,
    output logic rx_valid,
    output logic rx_sop,
    output logic rx_eop,
    output pkt_test_pkg::beat_t rx_data,
    output pkt_test_pkg::chan_t rx_chan
);
    import pkt_test_pkg::*;
    wire take = tx_valid && tx_ready;
    // random back-pressure
    always_ff @(posedge clk) begin
        tx_ready <= !rst_n || !stall || 1'($urandom_range(1));
    end
    // taken beats loop back a cycle later; idle lines show the inverse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_valid <= 1'b0;
            rx_sop <= 1'b0;
            rx_eop <= 1'b0;
            rx_data <= 64'h0;
            rx_chan <= 8'h00;
        end else begin
            rx_valid <= take;
            rx_sop <= take && tx_sop;
            rx_eop <= take && tx_eop;
            rx_data <= take ? tx_data : ~rx_data;
            rx_chan <= take ? (tx_chan ^ 8'(bad_chan)) : ~rx_chan;
        end
    end
endmodule // loop_link_model
`default_nettype wire

// File: dv/test_packet_test_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pkt_test_params.svh"
module test_packet_test_status_regs;
    import pkt_test_pkg::*;
    localparam int RUNS = 3;
    logic CLK = 1'b0, RST_N = 1'b0, MM_WRITE = 1'b0, MM_READ = 1'b0;
    logic stall = 1'b1, bad_chan = 1'b0;
    addr_t MM_ADDR = 8'h00;
    word_t MM_WDATA = 32'h0000_0000;
    word_t MM_RDATA, got;
    logic MM_RDVALID, TX_VALID, TX_READY, TX_SOP, TX_EOP, RX_VALID, RX_SOP, RX_EOP;
    beat_t TX_DATA, RX_DATA;
    chan_t TX_CHANNEL, RX_CHANNEL;
    logic [7:0] WORD_LOCK = 8'h00, SYNC_LOCK = 8'h00;
    logic [3:0] lv = 4'h0;
    logic [9:0] ev = 10'h000;
    int error_cnt = 0, checked = 0;
    addr_t zr[11] = '{8'h06, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h13, 8'h14, 8'h15, 8'h17, 8'h24};
    addr_t lr[5] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h11};
    addr_t cr[4] = '{8'h0C, 8'h0D, 8'h14, 8'h15};

    always #20 CLK = ~CLK;

    packet_test_status_regs #(.NUM_LANES(8), .PKT_WORDS(2), .RUN_PKTS(RUNS), .LOOKASIDE(1'b1)) DUT (
        .CLK(CLK), .RST_N(RST_N), .MM_ADDR(MM_ADDR), .MM_WRITE(MM_WRITE), .MM_READ(MM_READ),
        .MM_WDATA(MM_WDATA), .MM_RDATA(MM_RDATA), .MM_RDVALID(MM_RDVALID),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_SOP(TX_SOP), .TX_EOP(TX_EOP),
        .TX_DATA(TX_DATA), .TX_CHANNEL(TX_CHANNEL), .RX_VALID(RX_VALID), .RX_SOP(RX_SOP),
        .RX_EOP(RX_EOP), .RX_DATA(RX_DATA), .RX_CHANNEL(RX_CHANNEL), .RX_ALIGNED(lv[3]),
        .WORD_LOCK(WORD_LOCK), .SYNC_LOCK(SYNC_LOCK), .CRC32_ERR(ev[9]), .CRC24_ERR(ev[8]),
        .TX_UNDERFLOW(ev[2]), .TX_OVERFLOW(ev[1]), .RX_OVERFLOW(ev[0]),
        .LANE_ALIGN_LOSS(ev[5]), .ILLEGAL_CTRL_WORD(ev[4]), .ILLEGAL_FRAMING(ev[3]),
        .ECC_DETECTED(ev[7]), .ECC_CORRECTED(ev[6]), .PLL_LOCKED(lv[2]),
        .PLL_RST_REQ(lv[0]), .PLL_RST_EN(lv[1]));

    loop_link_model u_link (.clk(CLK), .rst_n(RST_N), .stall(stall), .bad_chan(bad_chan),
        .tx_valid(TX_VALID), .tx_sop(TX_SOP), .tx_eop(TX_EOP), .tx_data(TX_DATA),
        .tx_chan(TX_CHANNEL), .tx_ready(TX_READY), .rx_valid(RX_VALID), .rx_sop(RX_SOP),
        .rx_eop(RX_EOP), .rx_data(RX_DATA), .rx_chan(RX_CHANNEL));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input word_t g, input word_t e, input string m);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // strobes drop a cycle before the next request
    task automatic wr(input addr_t a, input word_t d);
        MM_ADDR = a;
        MM_WDATA = d;
        MM_WRITE = 1'b1;
        @(negedge CLK);
        MM_WRITE = 1'b0;
        @(negedge CLK);
    endtask

    // answer stands one cycle; taken at the next falling edge
    task automatic rd(input addr_t a);
        MM_ADDR = a;
        MM_READ = 1'b1;
        @(negedge CLK);
        MM_READ = 1'b0;
        got = (MM_RDVALID === 1'b1) ? MM_RDATA : 32'hDEAD_BEEF;
        @(negedge CLK);
    endtask

    task automatic rc(input addr_t a, input word_t e);
        rd(a);
        chk(got, e, $sformatf("register %h", a));
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge CLK);
    endtask

    // expected live register value
    function automatic word_t lvl_exp(input addr_t a);
        case (a)
            `OFS_RX_ALIGN: return {31'h0, lv[3]};
            `OFS_WORD_LOCK: return {24'h00_0000, WORD_LOCK};
            `OFS_SYNC_LOCK: return {24'h00_0000, SYNC_LOCK};
            `OFS_PLL_LOCK: return {31'h0, lv[2]};
            default: return {30'h0, lv[1:0]};
        endcase
    endfunction

    // main sequence
    initial begin
        int n32, n24, nerr, base;
        void'($urandom(53));
        idle(12);
        RST_N = 1'b1;
        foreach (zr[i]) rc(zr[i], 32'h0000_0000);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            lv = 4'($urandom);
            WORD_LOCK = (k == 0) ? 8'hFF : 8'($urandom);
            SYNC_LOCK = (k == 1) ? 8'h80 : 8'($urandom);
            foreach (lr[i]) rc(lr[i], lvl_exp(lr[i]));
        end
        $display("test live levels done");
        n32 = 0;
        n24 = 0;
        nerr = 0;
        repeat (25) begin
            ev = 10'($urandom);
            n32 += ev[9];
            n24 += ev[8];
            nerr += 32'(|ev[5:3]);
            @(negedge CLK);
        end
        ev = 10'h000;
        idle(2);
        rc(`OFS_CRC32_LO, 32'(n32));
        for (int a = 7; a < 10; a++) rc(8'(a), 32'h0000_0000);
        wr(`OFS_CRC24, 32'hFFFF_FFFF);
        rc(`OFS_CRC24, 32'(n24));
        rc(`OFS_ERR_CNT, 32'(nerr));
        rc(`OFS_FIFO_FLAGS, 32'h0000_0000);
        rc(`OFS_ECC_DET, 32'h0000_0000);
        rc(`OFS_ECC_CORR, 32'h0000_0000);
        $display("test event counters done");
        wr(`OFS_GEN_EN, 32'h0000_0001);
        idle(200);
        foreach (cr[i]) rc(cr[i], RUNS);
        rc(`OFS_CHK_ERR, 32'h0000_0000);
        rc(`OFS_CNT_EQUAL, 32'h0000_0001);
        wr(`OFS_EQ_CLEAR, 32'h0000_0001);
        rc(`OFS_CNT_EQUAL, 32'h0000_0000);
        rc(8'h30, 32'h0000_0000);
        rc(`OFS_LAT_START, 32'h0000_0000);
        $display("test bounded run done");
        wr(`OFS_LAT_START, 32'h0000_0001);
        wr(`OFS_GEN_EN, 32'h0000_0000);
        wr(`OFS_GEN_EN, 32'h0000_0001);
        idle(200);
        rc(`OFS_LAT_READY, 32'h0000_0001);
        rd(`OFS_LATENCY);
        chk(32'(got >= 1 && got <= 8), 32'h0000_0001, "latency range");
        foreach (cr[i]) rc(cr[i], 2 * RUNS);
        $display("test latency done");
        wr(`OFS_CONT, 32'h0000_0001);
        wr(`OFS_GEN_EN, 32'h0000_0000);
        wr(`OFS_GEN_EN, 32'h0000_0001);
        idle(400);
        rd(`OFS_TX_SOP_CNT);
        chk(32'(got > 3 * RUNS), 32'h0000_0001, "continuous count");
        wr(`OFS_GEN_EN, 32'h0000_0000);
        idle(20);
        rd(`OFS_TX_SOP_CNT);
        base = int'(got);
        idle(50);
        foreach (cr[i]) rc(cr[i], 32'(base));
        wr(`OFS_CONT, 32'h0000_0000);
        $display("test continuous done");
        bad_chan = 1'b1;
        wr(`OFS_GEN_EN, 32'h0000_0000);
        wr(`OFS_GEN_EN, 32'h0000_0001);
        idle(100);
        bad_chan = 1'b0;
        rd(`OFS_CHK_ERR);
        chk(got & 32'h0000_0002, 32'h0000_0002, "channel flag");
        $display("test checker flag done");
        RST_N = 1'b0;
        idle(2);
        RST_N = 1'b1;
        foreach (zr[i]) rc(zr[i], 32'h0000_0000);
        $display("test second reset done");
        conclude();
    end

    // sequence needs about 1200 cycles
    initial begin
        repeat (10000) @(posedge CLK);
        error_cnt++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        conclude();
    end
endmodule // test_packet_test_status_regs
`default_nettype wire
